// file: rtl/ast_top.sv
`timescale 1ns/1ps
`default_nettype none
module ast_top
  import ast_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [4:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_cpu_int_mask,
  input  wire logic        i_serial_rx_pin,
  output logic             o_serial_tx_pin,
  output logic             o_irq
);

  // ****************************************
  // State registers
  // ****************************************
  ast_state_t st_r;
  ast_state_t st_nxt;

  logic        acc;
  logic        wr_ok;
  logic        rd_data;
  logic        wr_data;
  logic [3:0]  pre;
  logic [18:0] tx_per;
  logic [18:0] rx_per;
  logic        tx_tick;
  logic        rx_tick;
  logic        word9;
  logic [3:0]  nbits;
  logic        pick;
  logic        maj;
  logic        dis;
  logic [8:0]  rx_word;
  logic [7:0]  idle_len;

  assign o_wb_ack        = st_r.ack;
  assign o_wb_dat        = st_r.dat;
  assign o_serial_tx_pin = st_r.txd;
  assign o_irq           = st_r.irq;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    st_nxt  = st_r;
    word9   = st_r.c1[C1_WORD9];
    nbits   = word9 ? BITS_9 : BITS_8;
    idle_len = {nbits, 4'h0} - 8'h01;
    // Access takes effect on the edge where the master sees ack
    acc     = i_wb_cyc & i_wb_stb & st_r.ack;
    wr_ok   = acc & i_wb_we & i_wb_sel[0];
    rd_data = acc & !i_wb_we & (i_wb_adr == ADR_DATA);
    wr_data = wr_ok & (i_wb_adr == ADR_DATA);

    // Bus answer: one wait cycle, ack drops the cycle after it rose
    st_nxt.ack = i_wb_cyc & i_wb_stb & !st_r.ack;
    st_nxt.dat = 32'h0000_0000;
    case (i_wb_adr)
      ADR_DATA:    st_nxt.dat[7:0] = st_r.rx_holding_buffer;
      ADR_STATUS:  st_nxt.dat[7:0] = {st_r.tx_empty_flag, st_r.tc, st_r.rx_full_flag,
                                      st_r.idle, st_r.ovr, st_r.nf,
                                      st_r.fe, 1'b0};
      ADR_CTRL1:   st_nxt.dat[7:0] = {st_r.r8, st_r.c1[6:0]};
      ADR_CTRL2:   st_nxt.dat[7:0] = st_r.c2;
      ADR_BAUD:    st_nxt.dat[7:0] = st_r.baud;
      ADR_RX_FINE: st_nxt.dat[7:0] = st_r.rx_fine;
      ADR_TX_FINE: st_nxt.dat[7:0] = st_r.tx_fine;
      default:     st_nxt.dat = 32'h0000_0000;
    endcase

    // Register writes; software keeps baud fixed while enabled
    if (wr_ok) begin
      case (i_wb_adr)
        ADR_CTRL1:   st_nxt.c1 = {1'b0, i_wb_dat[6:0]};
        ADR_CTRL2:   st_nxt.c2 = i_wb_dat[7:0];
        ADR_BAUD:    st_nxt.baud = i_wb_dat[7:0];
        ADR_RX_FINE: st_nxt.rx_fine = i_wb_dat[7:0];
        ADR_TX_FINE: st_nxt.tx_fine = i_wb_dat[7:0];
        default:     st_nxt.c1 = st_nxt.c1;
      endcase
    end

    // Status read arms the clear; any data access consumes it
    if (acc && !i_wb_we && i_wb_adr == ADR_STATUS) begin
      st_nxt.sr_seen = 1'b1;
    end else if (acc && i_wb_adr == ADR_DATA) begin
      st_nxt.sr_seen = 1'b0;
    end
    if (wr_data && st_r.sr_seen) begin
      st_nxt.tx_empty_flag = 1'b0;
      st_nxt.tc   = 1'b0;
    end
    if (rd_data && st_r.sr_seen) begin
      st_nxt.rx_full_flag = 1'b0;
      st_nxt.ovr  = 1'b0;
      st_nxt.nf   = 1'b0;
      st_nxt.fe   = 1'b0;
      st_nxt.idle = 1'b0;
    end
    // A write always lands in the holding buffer first
    if (wr_data) begin
      st_nxt.tx_holding_buffer      = i_wb_dat[7:0];
      st_nxt.tdr_full = 1'b1;
    end

    // Baud generation: 16x tick every pre*2^sel*fine cycles
    case (st_r.baud[7:6])
      2'b00:   pre = PRE_1;
      2'b01:   pre = PRE_3;
      2'b10:   pre = PRE_4;
      default: pre = PRE_13;
    endcase
    tx_per = 19'(pre) * (19'h00001 << st_r.baud[5:3])
           * 19'((st_r.tx_fine == 8'h00) ? 8'h01 : st_r.tx_fine);
    rx_per = 19'(pre) * (19'h00001 << st_r.baud[2:0])
           * 19'((st_r.rx_fine == 8'h00) ? 8'h01 : st_r.rx_fine);
    tx_tick = st_r.c2[C2_TE] && (st_r.tx_div >= tx_per - 19'h00001);
    rx_tick = st_r.c2[C2_RE] && (st_r.rx_div >= rx_per - 19'h00001);
    st_nxt.tx_div = (tx_tick || !st_r.c2[C2_TE]) ? 19'h00000
                                                  : st_r.tx_div + 19'h00001;
    st_nxt.rx_div = (rx_tick || !st_r.c2[C2_RE]) ? 19'h00000
                                                  : st_r.rx_div + 19'h00001;

    // ****************************************
    // Transmitter
    // ****************************************
    st_nxt.te_d = st_r.c2[C2_TE];
    if (st_r.c2[C2_TE] && !st_r.te_d) begin
      st_nxt.idle_pend = 1'b1;
      if (st_r.tx_busy) begin
        st_nxt.tdr_full = 1'b0;
      end
    end
    pick = 1'b0;
    if (st_r.tx_busy && tx_tick) begin
      st_nxt.tx_sub = st_r.tx_sub + 4'h1;
      if (st_r.tx_sub == SUB_LAST) begin
        st_nxt.tx_sh  = {1'b1, st_r.tx_sh[10:1]};
        st_nxt.tx_cnt = st_r.tx_cnt - 4'h1;
        if (st_r.tx_cnt == 4'h1) begin
          pick = 1'b1;
          st_nxt.tx_busy = 1'b0;
        end
      end
    end else if (!st_r.tx_busy && st_r.c2[C2_TE]) begin
      pick = 1'b1;
    end
    // Choose the next frame; idle, then break, then data
    if (pick && st_r.c2[C2_TE]) begin
      st_nxt.tx_sub = 4'h0;
      st_nxt.tx_cnt = nbits;
      if (st_nxt.idle_pend) begin
        st_nxt.idle_pend = 1'b0;
        st_nxt.tx_busy   = 1'b1;
        st_nxt.tx_sh     = 11'h7FF;
      end else if (st_r.c2[C2_SBK]) begin
        st_nxt.brk_sent = 1'b1;
        st_nxt.tx_busy  = 1'b1;
        st_nxt.tx_sh    = 11'h000;
      end else if (st_r.brk_sent) begin
        st_nxt.brk_sent = 1'b0;
        st_nxt.tx_busy  = 1'b1;
        st_nxt.tx_cnt   = 4'h1;
        st_nxt.tx_sh    = 11'h7FF;
      end else if (st_r.tdr_full) begin
        st_nxt.tdr_full = wr_data;
        st_nxt.tx_busy  = 1'b1;
        st_nxt.tx_empty_flag     = 1'b1;
        // Start low, stop high; ninth bit from control field
        st_nxt.tx_sh = word9 ? {1'b1, st_r.c1[C1_T8], st_r.tx_holding_buffer, 1'b0}
                             : {2'b11, st_r.tx_holding_buffer, 1'b0};
      end else if (st_r.tx_busy) begin
        st_nxt.tc = 1'b1;
      end
    end else if (pick && st_r.tx_busy) begin
      st_nxt.tc = 1'b1;
    end
    // Line idles high whenever nothing is shifting
    st_nxt.txd = st_nxt.tx_busy ? st_nxt.tx_sh[0] : 1'b1;

    // ****************************************
    // Receiver
    // ****************************************
    maj = (st_r.rx_smp[0] & st_r.rx_smp[1])
        | (st_r.rx_smp[0] & i_serial_rx_pin)
        | (st_r.rx_smp[1] & i_serial_rx_pin);
    dis = !((st_r.rx_smp[0] == st_r.rx_smp[1])
         && (st_r.rx_smp[1] == i_serial_rx_pin));
    rx_word = word9 ? st_r.rx_sh : {1'b0, st_r.rx_sh[8:1]};
    if (!st_r.c2[C2_RE]) begin
      st_nxt.rx_st    = AST_RX_HUNT;
      st_nxt.rx_hist  = 3'h0;
      st_nxt.idle_cnt = 8'h00;
    end else if (rx_tick) begin
      case (st_r.rx_st)
        AST_RX_HUNT: begin
          st_nxt.rx_hist = {st_r.rx_hist[1:0], i_serial_rx_pin};
          // Full frame of ones is an idle character
          if (i_serial_rx_pin) begin
            st_nxt.idle_cnt = (st_r.idle_cnt == idle_len) ? 8'h00
                            : st_r.idle_cnt + 8'h01;
            if (st_r.idle_cnt == idle_len && st_r.idle_armed) begin
              st_nxt.idle       = 1'b1;
              st_nxt.idle_armed = 1'b0;
            end
          end else begin
            st_nxt.idle_cnt = 8'h00;
          end
          // Three highs then a low restarts the sample clock
          if (!i_serial_rx_pin && st_r.rx_hist == 3'h7) begin
            st_nxt.rx_st    = AST_RX_FRAME;
            st_nxt.rx_sub   = 4'h1;
            st_nxt.rx_bit   = 4'h0;
            st_nxt.rx_noise = 1'b0;
          end
        end
        AST_RX_FRAME: begin
          st_nxt.rx_sub = st_r.rx_sub + 4'h1;
          if (st_r.rx_sub >= SUB_S8) begin
            st_nxt.rx_smp = {st_r.rx_smp[0], i_serial_rx_pin};
          end
          // Samples 3, 5 and 7 of the start bit must be low
          if (st_r.rx_bit == 4'h0 && !st_r.rx_sub[0]
              && st_r.rx_sub < SUB_S8 && i_serial_rx_pin) begin
            st_nxt.rx_noise = 1'b1;
          end
          if (st_r.rx_sub == SUB_S10) begin
            if (dis) begin
              st_nxt.rx_noise = 1'b1;
            end
            if (st_r.rx_bit == 4'h0 && maj) begin
              // False start: drop frame, keep noise for later
              st_nxt.rx_st   = AST_RX_HUNT;
              st_nxt.nf_pend = 1'b1;
              st_nxt.rx_hist = 3'h0;
            end else if (st_r.rx_bit != 4'h0
                         && st_r.rx_bit < nbits - 4'h1) begin
              st_nxt.rx_sh = {maj, st_r.rx_sh[8:1]};
            end else if (st_r.rx_bit == nbits - 4'h1) begin
              st_nxt.rx_st      = AST_RX_HUNT;
              st_nxt.rx_hist    = maj ? 3'h7 : 3'h0;
              st_nxt.idle_armed = 1'b1;
              st_nxt.idle_cnt   = 8'h00;
              if (st_r.rx_full_flag) begin
                st_nxt.ovr = 1'b1;
              end else begin
                st_nxt.rx_full_flag    = 1'b1;
                st_nxt.rx_holding_buffer     = rx_word[7:0];
                st_nxt.r8      = rx_word[8];
                // Break or missing stop both give a framing error
                st_nxt.fe      = !maj;
                st_nxt.nf      = st_r.nf_pend | st_nxt.rx_noise;
                st_nxt.nf_pend = 1'b0;
              end
            end
          end
          if (st_r.rx_sub == SUB_LAST) begin
            st_nxt.rx_bit = st_r.rx_bit + 4'h1;
          end
        end
        default: st_nxt.rx_st = AST_RX_HUNT;
      endcase
    end

    // Single request gated by the CPU mask
    st_nxt.irq = !i_cpu_int_mask
      & ((st_nxt.tx_empty_flag & st_r.c2[C2_TIE])
       | (st_nxt.tc & st_r.c2[C2_TX_COMPLETE_IRQ_EN])
       | ((st_nxt.rx_full_flag | st_nxt.ovr) & st_r.c2[C2_RIE])
       | (st_nxt.idle & st_r.c2[C2_IDLE_LINE_IRQ_EN]));
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r         <= '0;
      st_r.txd     <= 1'b1;
      st_r.tx_empty_flag    <= RST_TXFLG[1];
      st_r.tc      <= RST_TXFLG[0];
      st_r.rx_st   <= AST_RX_HUNT;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule
`default_nettype wire

// file: include/ast_pkg.sv
// Summary of operation
// - Data word is 8 bits with word-length bit clear, 9 when set.
// - Transmit line low for the whole start bit, high for the stop bit.
// - Transmit LSB first; ninth bit comes from the transmit-ninth-bit field.
// - Transmit-empty clears only on status read followed by data write.
// - Transmit-empty requests interrupt when enabled and global mask clear.
// - Data write during a frame goes to buffer, moved when frame ends.
// - Data write while idle loads shifter, starts, sets transmit-empty.
// - After stop bit with nothing pending set complete flag, interrupt if enabled.
// - Complete flag clears by the same status-read then data-write sequence.
// - Send-break keeps sending zero frames, then one extra high bit.
// - Enabling transmitter sends an idle frame; re-enable mid-frame drops buffer.
// - Receive LSB first; received ninth bit goes to bit 7 of the control field.
// - Enabling the receiver starts the hunt for a start bit.
// - Completed character moves to buffer, sets full flag, interrupt if enabled.
// - Full flag clears on status read followed by data read.
// - A received break counts as a framing error.
// - Idle frame after a character sets only the idle flag, idle-line interrupt if enabled.
// - Character into full buffer sets overrun, keeps buffer, interrupts if enabled.
// - Bit valid only when samples 8,9,10 agree, else noise flag with full.
// - False start bit discards frame, noise held for the next good frame.
// - Missing stop bit or break sets framing error, data still transferred.
// - Baud is clock over 16, common prescale 1/3/4/13, divider 1..128.
// - Nonzero fine prescale 1..255 further divides that direction's clock.
// - Sixteen samples per bit, resync at each start, majority of 8..10.
package ast_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [4:0] ADR_DATA     = 5'h00;
  localparam logic [4:0] ADR_STATUS   = 5'h04;
  localparam logic [4:0] ADR_CTRL1    = 5'h08;
  localparam logic [4:0] ADR_CTRL2    = 5'h0C;
  localparam logic [4:0] ADR_BAUD     = 5'h10;
  localparam logic [4:0] ADR_RX_FINE  = 5'h14;
  localparam logic [4:0] ADR_TX_FINE  = 5'h18;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int C1_WORD9 = 0;
  localparam int C1_T8    = 1;
  localparam int C1_R8    = 7;
  localparam int C2_SBK   = 0;
  localparam int C2_RE    = 2;
  localparam int C2_TE    = 3;
  localparam int C2_IDLE_LINE_IRQ_EN  = 4;
  localparam int C2_RIE   = 5;
  localparam int C2_TX_COMPLETE_IRQ_EN  = 6;
  localparam int C2_TIE   = 7;
  localparam int SR_FE    = 1;
  localparam int SR_NF    = 2;
  localparam int SR_OR    = 3;
  localparam int SR_IDLE  = 4;
  localparam int SR_RX_FULL_FLAG  = 5;
  localparam int SR_TC    = 6;
  localparam int SR_TX_EMPTY_FLAG  = 7;

  // ****************************************
  // Timing constants
  // ****************************************
  localparam logic [3:0] SUB_LAST   = 4'hF;  // Sample 16 of a bit
  localparam logic [3:0] SUB_S8     = 4'h7;
  localparam logic [3:0] SUB_S10    = 4'h9;
  localparam logic [3:0] BITS_8     = 4'hA;  // Start + 8 + stop
  localparam logic [3:0] BITS_9     = 4'hB;  // Start + 9 + stop
  localparam logic [3:0] PRE_1      = 4'h1;
  localparam logic [3:0] PRE_3      = 4'h3;
  localparam logic [3:0] PRE_4      = 4'h4;
  localparam logic [3:0] PRE_13     = 4'hD;
  localparam logic [1:0] RST_TXFLG  = 2'h3;  // Empty and complete at reset

  typedef enum logic {AST_RX_HUNT, AST_RX_FRAME} ast_rx_st_t;

  // ****************************************
  // Whole state of the block
  // ****************************************
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    logic        irq;
    logic        txd;
    logic [7:0]  c1;
    logic [7:0]  c2;
    logic [7:0]  baud;
    logic [7:0]  rx_fine;
    logic [7:0]  tx_fine;
    logic        sr_seen;
    logic        tx_empty_flag;
    logic        tc;
    logic        rx_full_flag;
    logic        idle;
    logic        ovr;
    logic        nf;
    logic        fe;
    logic        r8;
    logic [7:0]  rx_holding_buffer;
    logic [7:0]  tx_holding_buffer;
    logic        tdr_full;
    logic        te_d;
    logic        idle_pend;
    logic        brk_sent;
    logic        tx_busy;
    logic [10:0] tx_sh;
    logic [3:0]  tx_cnt;
    logic [3:0]  tx_sub;
    logic [18:0] tx_div;
    logic [18:0] rx_div;
    ast_rx_st_t  rx_st;
    logic [3:0]  rx_sub;
    logic [3:0]  rx_bit;
    logic [2:0]  rx_hist;
    logic [1:0]  rx_smp;
    logic        rx_noise;
    logic        nf_pend;
    logic [8:0]  rx_sh;
    logic [7:0]  idle_cnt;
    logic        idle_armed;
  } ast_state_t;

endpackage

// file: verif/ast_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ast_chk
  import ast_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [4:0]  i_wb_adr,
  input wire logic [3:0]  i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic        i_cpu_int_mask,
  input wire logic        i_serial_rx_pin,
  input wire logic        o_serial_tx_pin,
  input wire logic        o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // ****************************************
  // Length of the present level on the line
  // ****************************************
  logic        tx_q;
  logic        seen;
  logic [15:0] run;

  // Saturates so a long idle line cannot wrap into a short run
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_q <= 1'b1;
      seen <= 1'b0;
      run  <= 16'h0000;
    end else begin
      tx_q <= o_serial_tx_pin;
      seen <= seen | (o_serial_tx_pin != tx_q);
      if (o_serial_tx_pin != tx_q) begin
        run <= 16'h0000;
      end else if (run != 16'hFFFF) begin
        run <= run + 16'h0001;
      end
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  property p_ack_resp;
    $rose(i_wb_cyc && i_wb_stb) |=> o_wb_ack;
  endproperty
  a_ack_resp: assert property (p_ack_resp)
    else $error("request not answered next cycle");

  property p_ack_pulse;
    o_wb_ack |=> !o_wb_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");

  property p_ack_cause;
    o_wb_ack |-> $past(i_wb_cyc && i_wb_stb);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");

  property p_dat_upper;
    o_wb_ack |-> o_wb_dat[31:8] == 24'h000000;
  endproperty
  a_dat_upper: assert property (p_dat_upper)
    else $error("upper read data not zero");

  property p_unmapped;
    (o_wb_ack && !$past(i_wb_we) && $past(i_wb_adr) > ADR_TX_FINE)
      |-> o_wb_dat == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_irq_mask;
    (i_cpu_int_mask && $past(i_cpu_int_mask)) |-> !o_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt while masked");

  property p_irq_rise;
    $rose(o_irq) |-> !$past(i_cpu_int_mask);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt rose under mask");

  property p_tx_bit;
    (seen && o_serial_tx_pin != tx_q) |-> run >= 16'h000F;
  endproperty
  a_tx_bit: assert property (p_tx_bit)
    else $error("line level shorter than 16 clocks");
endmodule

bind ast_top ast_chk u_chk (.i_clk, .i_rstn, .i_wb_cyc, .i_wb_stb,
  .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack,
  .i_cpu_int_mask, .i_serial_rx_pin, .o_serial_tx_pin, .o_irq);
`default_nettype wire

// file: verif/ast_peer.sv
`timescale 1ns/1ps
`default_nettype none
module ast_peer (
  input  wire logic i_clk,
  input  wire logic i_line,
  output logic      o_line
);
  // ****************************************
  // Far-side serial equipment
  // ****************************************
  int         watch_clks = 16;
  int         drive_clks = 16;
  int         nbits      = 8;
  logic [9:0] got_q[$];

  // Idle line is high between frames
  initial o_line = 1'b1;

  // Start low, data LSB first, chosen stop level, then back to idle
  task automatic send(input logic [8:0] d, input logic stp);
    for (int i = 0; i < nbits + 2; i++) begin
      @(posedge i_clk);
      o_line <= (i == 0) ? 1'b0 : (i == nbits + 1) ? stp : d[i - 1];
      repeat (drive_clks - 1) @(posedge i_clk);
    end
    @(posedge i_clk);
    o_line <= 1'b1;
  endtask

  // Mid-bit sampler; a break keeps it parked until the line goes high
  initial begin
    logic [9:0] f;
    forever begin
      @(posedge i_clk iff i_line === 1'b1);
      @(posedge i_clk iff i_line === 1'b0);
      repeat (watch_clks / 2) @(posedge i_clk);
      f = 10'h000;
      for (int i = 0; i <= nbits; i++) begin
        repeat (watch_clks) @(posedge i_clk);
        f[(i == nbits) ? 9 : i] = i_line;
      end
      got_q.push_back(f);
    end
  end
endmodule
`default_nettype wire

// file: verif/async_serial_transceiver_tb.sv
`timescale 1ns/1ps
`default_nettype none
module async_serial_transceiver_tb
  import ast_pkg::*;
;
  logic        i_clk;
  logic        i_rstn;
  logic        i_wb_cyc;
  logic        i_wb_stb;
  logic        i_wb_we;
  logic [4:0]  i_wb_adr;
  logic [3:0]  i_wb_sel;
  logic [31:0] i_wb_dat;
  logic [31:0] o_wb_dat;
  logic        o_wb_ack;
  logic        i_cpu_int_mask;
  logic        i_serial_rx_pin;
  logic        o_serial_tx_pin;
  logic        o_irq;
  int          n_mismatch;
  int          comparisons;
  int          nq;

  ast_top DUT (.i_clk, .i_rstn, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
    .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_cpu_int_mask,
    .i_serial_rx_pin, .o_serial_tx_pin, .o_irq);
  ast_peer peer (.i_clk(i_clk), .i_line(o_serial_tx_pin),
    .o_line(i_serial_rx_pin));

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request held until ack is sampled high; a hung bus ends the run
  task automatic wb(input logic we, input logic [4:0] a,
                    input logic [7:0] d, output logic [31:0] q);
    int n;
    @(posedge i_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= we;
    i_wb_adr <= a;
    i_wb_dat <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      report_and_stop();
    end
    q = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(q & m, e);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  // Status read then data write, as software must do per byte
  task automatic put(input logic [7:0] d);
    logic [31:0] q;
    wb(1'b0, ADR_STATUS, 8'h00, q);
    wr(ADR_DATA, d);
  endtask

  // Next frame seen by the far side as {stop, data}
  task automatic get_frame(input logic [9:0] e);
    int n;
    n = 0;
    while (peer.got_q.size() <= nq && n < 20000) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 20000) begin
      n_mismatch++;
      report_and_stop();
    end
    chk({22'h000000, peer.got_q[nq]}, {22'h000000, e});
    nq++;
  endtask

  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  initial begin
    repeat (100000) @(posedge i_clk);
    n_mismatch++;
    report_and_stop();
  end

  // Fixed waits below are plain clock counts, not whole bit or frame times
  initial begin
    i_rstn = 1'b0;
    i_wb_cyc = 1'b0;
    i_wb_stb = 1'b0;
    i_wb_we = 1'b0;
    i_wb_adr = 5'h00;
    i_wb_sel = 4'hF;
    i_wb_dat = 32'h00000000;
    i_cpu_int_mask = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    nq = 0;
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(ADR_STATUS, 32'hC0, 32'hFE);
    rd(5'h1C, 32'h0, 32'hFFFFFFFF);
    wr(ADR_CTRL2, 8'h2C);
    put(8'hA5);
    rd(ADR_STATUS, 32'h00, 32'h80);
    repeat (200) @(posedge i_clk);
    put(8'h3C);
    rd(ADR_STATUS, 32'h00, 32'h80);
    get_frame(10'h2A5);
    get_frame(10'h23C);
    repeat (30) @(posedge i_clk);
    rd(ADR_STATUS, 32'hC0, 32'hC0);
    wr(ADR_CTRL1, 8'h03);
    peer.nbits = 9;
    put(8'h00);
    get_frame(10'h300);
    peer.send(9'h1C3, 1'b1);
    repeat (4) @(posedge i_clk);
    chk({31'h0, o_irq}, 32'h1);
    i_cpu_int_mask <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk({31'h0, o_irq}, 32'h0);
    i_cpu_int_mask <= 1'b0;
    rd(ADR_CTRL1, 32'h80, 32'h80);
    rd(ADR_STATUS, 32'h20, 32'h2E);
    rd(ADR_DATA, 32'hC3, 32'hFF);
    rd(ADR_STATUS, 32'h00, 32'h20);
    // A full frame time of high line after a character flags idle
    repeat (200) @(posedge i_clk);
    rd(ADR_STATUS, 32'h10, 32'h10);
    wr(ADR_CTRL1, 8'h00);
    peer.nbits = 8;
    peer.send(9'h011, 1'b1);
    peer.send(9'h022, 1'b1);
    repeat (4) @(posedge i_clk);
    rd(ADR_STATUS, 32'h28, 32'h2E);
    rd(ADR_DATA, 32'h11, 32'hFF);
    rd(ADR_STATUS, 32'h00, 32'h28);
    peer.send(9'h000, 1'b0);
    repeat (4) @(posedge i_clk);
    rd(ADR_STATUS, 32'h22, 32'h22);
    rd(ADR_DATA, 32'h00, 32'hFF);
    wr(ADR_CTRL2, 8'h2D);
    get_frame(10'h000);
    wr(ADR_CTRL2, 8'h2C);
    put(8'h5A);
    get_frame(10'h25A);
    repeat (200) @(posedge i_clk);
    wr(ADR_CTRL2, 8'h00);
    // A write without the low byte lane must be ignored
    i_wb_sel <= 4'hE;
    wr(ADR_TX_FINE, 8'h55);
    i_wb_sel <= 4'hF;
    rd(ADR_TX_FINE, 32'h00, 32'hFF);
    wr(ADR_BAUD, 8'h48);
    wr(ADR_TX_FINE, 8'h02);
    peer.watch_clks = 192;
    peer.drive_clks = 48;
    wr(ADR_CTRL2, 8'h2C);
    put(8'h96);
    get_frame(10'h296);
    peer.send(9'h069, 1'b1);
    repeat (4) @(posedge i_clk);
    rd(ADR_STATUS, 32'h20, 32'h2E);
    rd(ADR_DATA, 32'h69, 32'hFF);
    // Transmit-empty is set here; only its enable decides the request
    wr(ADR_CTRL2, 8'h8C);
    repeat (2) @(posedge i_clk);
    chk({31'h0, o_irq}, 32'h1);
    wr(ADR_CTRL2, 8'h0C);
    repeat (2) @(posedge i_clk);
    chk({31'h0, o_irq}, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
